// File: verilog/vfs_regs.sv
// fetch level thresholds, colour constants, line position and frame signature registers
`timescale 1ns/1ns
// Notes on behaviour
// - bits 10:8 pick the window two fetch level 2,3,4,5,6,8,10,12 for codes 0 to 7.
// - bits 6:4 pick the window one fetch level with the same code table.
// - bits 2:0 pick the graphics fetch level with the same code table.
// - each fetch buffer requests memory while its empty count is at least its level.
// - the threshold register resets to 00000444h, level six for all three buffers.
// - the colour register holds red 23:16, green 15:8, blue 7:0 and resets to EDEDEDh.
// - the line register reads the current line in bits 10:0 and ignores writes.
// - the signature in bits 31:16 is read only and writes leave it alone.
// - software sets the run bit to start, hardware clears it when the frame is done.
// - software sets the clear bit first, and while set the signature is held at zero.
// - with run and clear both set, the clear bit drops at the next vertical sync.
// - source code 00 takes red, 01 green and 1x blue.
module vfs_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire vfs_pkg::vfs_addr_type paddr,
  input wire vfs_pkg::vfs_data_type pwdata,
  output vfs_pkg::vfs_data_type prdata,
  output logic pready,
  output logic pslverr,
  // display timing and colour inputs
  input wire logic vsyncPulse,
  input wire logic pixelValid,
  input wire vfs_pkg::vfs_pixel_type pixelIn,
  input wire logic [vfs_pkg::LINE_W-1:0] scanLine,
  // fetch buffers
  input wire logic [vfs_pkg::COUNT_W-1:0] graphicsEmpty,
  input wire logic [vfs_pkg::COUNT_W-1:0] windowOneEmpty,
  input wire logic [vfs_pkg::COUNT_W-1:0] windowTwoEmpty,
  output logic graphicsReq,
  output logic windowOneReq,
  output logic windowTwoReq,
  // interrupt
  output logic irq
);
  import vfs_pkg::*;

  vfs_threshold_type thresholdReg;
  vfs_colour_type colourReg;
  vfs_ana_state_type stateReg;
  logic clearFlagReg;
  logic [1:0] srcSelReg;
  logic [7:0] pixByteReg;
  logic pixValidReg;
  logic [IRQ_W-1:0] irqStatusReg;
  logic [IRQ_W-1:0] irqStatusNext;
  logic [IRQ_W-1:0] irqEnableReg;
  logic [SIG_W-1:0] signature;
  vfs_data_type readData;
  logic readHit;
  logic access;
  logic commitWrite;
  logic sigWrite;
  logic runFlag;
  logic frameDone;
  vfs_threshold_type thresholdIn;
  vfs_colour_type colourIn;

  // ----------------------------------------
  // apb handshake
  // ----------------------------------------
  // one wait state: pready rises in the second access cycle, so read data is a register
  assign access = psel && penable && !pready;
  assign commitWrite = psel && penable && pready && pwrite;
  assign sigWrite = commitWrite && (paddr == OFF_SIGNATURE_CTRL);
  assign runFlag = (stateReg != ANA_IDLE);
  assign frameDone = (stateReg == ANA_ACTIVE) && vsyncPulse;
  // field views of the write data, so no bit position is spelled out twice
  assign thresholdIn = pwdata;
  assign colourIn = pwdata;

  always_comb begin
    readData = '0;
    readHit = 1'b1;
    unique case (paddr)
      OFF_FETCH_THRESHOLD: readData = thresholdReg;
      OFF_COLOUR_CONSTANTS: readData = colourReg;
      OFF_LINE_POSITION: readData[LINE_W-1:0] = scanLine;
      OFF_SIGNATURE_CTRL: begin
        readData[SIG_LSB +: SIG_W] = signature;
        readData[RUN_BIT] = runFlag;
        readData[CLEAR_BIT] = clearFlagReg;
        readData[SRC_MSB:SRC_LSB] = srcSelReg;
      end
      OFF_IRQ_STATUS: readData[IRQ_W-1:0] = irqStatusReg;
      OFF_IRQ_CLEAR: readData = '0;
      OFF_IRQ_ENABLE: readData[IRQ_W-1:0] = irqEnableReg;
      default: readHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (access) begin
      pready <= 1'b1;
      pslverr <= !readHit;
      prdata <= pwrite ? '0 : readData;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // threshold and colour registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thresholdReg <= THRESHOLD_RESET;
    end else if (commitWrite && paddr == OFF_FETCH_THRESHOLD) begin
      // only the three code fields take data, reserved bits stay zero
      thresholdReg.windowTwoFetchThreshold <= thresholdIn.windowTwoFetchThreshold;
      thresholdReg.windowOneFetchThreshold <= thresholdIn.windowOneFetchThreshold;
      thresholdReg.graphicsFetchThreshold <= thresholdIn.graphicsFetchThreshold;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      colourReg <= COLOUR_RESET;
    end else if (commitWrite && paddr == OFF_COLOUR_CONSTANTS) begin
      colourReg.red <= colourIn.red;
      colourReg.green <= colourIn.green;
      colourReg.blue <= colourIn.blue;
    end
  end

  // ----------------------------------------
  // fetch requests
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      graphicsReq <= 1'b0;
      windowOneReq <= 1'b0;
      windowTwoReq <= 1'b0;
    end else begin
      graphicsReq <= graphicsEmpty >= fetchLevel(thresholdReg.graphicsFetchThreshold);
      windowOneReq <= windowOneEmpty >= fetchLevel(thresholdReg.windowOneFetchThreshold);
      windowTwoReq <= windowTwoEmpty >= fetchLevel(thresholdReg.windowTwoFetchThreshold);
    end
  end

  // ----------------------------------------
  // analyzer control
  // ----------------------------------------
  // a software write of run wins over the end of frame in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= ANA_IDLE;
    end else if (sigWrite && !pwdata[RUN_BIT]) begin
      stateReg <= ANA_IDLE;
    end else if (sigWrite && (stateReg == ANA_IDLE || frameDone)) begin
      stateReg <= ANA_ARMED;
    end else begin
      unique case (stateReg)
        ANA_IDLE: stateReg <= ANA_IDLE;
        ANA_ARMED: if (vsyncPulse) begin
          stateReg <= ANA_ACTIVE;
        end
        ANA_ACTIVE: if (vsyncPulse) begin
          stateReg <= ANA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clearFlagReg <= 1'b0;
      srcSelReg <= SRC_RED;
    end else if (sigWrite) begin
      clearFlagReg <= pwdata[CLEAR_BIT];
      srcSelReg <= pwdata[SRC_MSB:SRC_LSB];
    end else if (clearFlagReg && runFlag && vsyncPulse) begin
      clearFlagReg <= 1'b0;
    end
  end

  // ----------------------------------------
  // analyzer datapath
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pixByteReg <= 8'h00;
      pixValidReg <= 1'b0;
    end else begin
      if (srcSelReg[1]) begin
        pixByteReg <= pixelIn.blue;
      end else if (srcSelReg == SRC_GREEN) begin
        pixByteReg <= pixelIn.green;
      end else begin
        pixByteReg <= pixelIn.red;
      end
      pixValidReg <= pixelValid && (stateReg == ANA_ACTIVE);
    end
  end

  vfs_signature u_signature (
    .clk(clk),
    .rst_n(rst_n),
    .forceZero(clearFlagReg),
    .shiftEn(pixValidReg),
    .dataIn(pixByteReg),
    .signature(signature)
  );

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  // hardware events beat a clear written in the same cycle
  always_comb begin
    irqStatusNext = irqStatusReg;
    if (commitWrite && paddr == OFF_IRQ_CLEAR) begin
      irqStatusNext = irqStatusNext & ~pwdata[IRQ_W-1:0];
    end
    if (frameDone) begin
      irqStatusNext[IRQ_DONE] = 1'b1;
    end
    if (vsyncPulse) begin
      irqStatusNext[IRQ_FRAME] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatusReg <= '0;
    end else begin
      irqStatusReg <= irqStatusNext;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqEnableReg <= '0;
    end else if (commitWrite && paddr == OFF_IRQ_ENABLE) begin
      irqEnableReg <= pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatusReg & irqEnableReg);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence readLineSeq;
    access && !pwrite && paddr == OFF_LINE_POSITION;
  endsequence

  a_thresh_reset: assert property (
    @(posedge clk) disable iff (1'b0) !rst_n |-> thresholdReg == THRESHOLD_RESET
  ) else $error("threshold register not at reset value");

  a_colour_reset: assert property (
    @(posedge clk) disable iff (1'b0) !rst_n |-> colourReg == COLOUR_RESET
  ) else $error("colour register not at reset value");

  a_graphics_request: assert property (
    1'b1 |=> graphicsReq == ($past(graphicsEmpty)
      >= fetchLevel($past(thresholdReg.graphicsFetchThreshold)))
  ) else $error("graphics request does not follow level");

  a_window_one_req: assert property (
    1'b1 |=> windowOneReq == ($past(windowOneEmpty)
      >= fetchLevel($past(thresholdReg.windowOneFetchThreshold)))
  ) else $error("window one request does not follow level");

  a_window_two_req: assert property (
    1'b1 |=> windowTwoReq == ($past(windowTwoEmpty)
      >= fetchLevel($past(thresholdReg.windowTwoFetchThreshold)))
  ) else $error("window two request does not follow level");

  a_line_readback: assert property (
    readLineSeq |=> pready && prdata == vfs_data_type'($past(scanLine))
  ) else $error("line position read wrong");

  a_signature_ro: assert property (
    sigWrite && stateReg == ANA_IDLE && !clearFlagReg |=> $stable(signature)
  ) else $error("signature changed by a write");

  a_run_ends: assert property (
    frameDone && !sigWrite |=> !runFlag ##1 (!runFlag || $past(sigWrite))
  ) else $error("run bit not cleared at end of frame");

  a_clear_auto: assert property (
    clearFlagReg && runFlag && vsyncPulse && !sigWrite |=> !clearFlagReg
  ) else $error("clear bit not released at vertical sync");

  a_source_blue: assert property (
    srcSelReg[1] |=> pixByteReg == $past(pixelIn.blue)
  ) else $error("blue source not selected");

  a_irq_level: assert property (
    1'b1 |=> irq == $past(|(irqStatusReg & irqEnableReg))
  ) else $error("interrupt level wrong");

endmodule : vfs_regs

// File: verilog/vfs_pkg.sv
// package: register map, field layouts and constants of the fetch level and signature block
package vfs_pkg;

  // ----------------------------------------
  // bus and register offsets
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  typedef logic [ADDR_W-1:0] vfs_addr_type;
  typedef logic [DATA_W-1:0] vfs_data_type;

  localparam vfs_addr_type OFF_FETCH_THRESHOLD = 12'h058;
  localparam vfs_addr_type OFF_COLOUR_CONSTANTS = 12'h05c;
  localparam vfs_addr_type OFF_LINE_POSITION = 12'h060;
  localparam vfs_addr_type OFF_SIGNATURE_CTRL = 12'h064;
  localparam vfs_addr_type OFF_IRQ_STATUS = 12'h070;
  localparam vfs_addr_type OFF_IRQ_CLEAR = 12'h074;
  localparam vfs_addr_type OFF_IRQ_ENABLE = 12'h078;

  // ----------------------------------------
  // field layouts
  // ----------------------------------------
  typedef struct packed {
    logic [20:0] reservedHigh;
    logic [2:0] windowTwoFetchThreshold;
    logic reservedSeven;
    logic [2:0] windowOneFetchThreshold;
    logic reservedThree;
    logic [2:0] graphicsFetchThreshold;
  } vfs_threshold_type;

  typedef struct packed {
    logic [7:0] reservedHigh;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } vfs_colour_type;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } vfs_pixel_type;

  localparam vfs_data_type THRESHOLD_RESET = 32'h00000444;
  localparam vfs_data_type COLOUR_RESET = 32'h00ededed;

  localparam int LINE_W = 11;
  localparam int COUNT_W = 5;
  localparam int SIG_W = 16;
  localparam int SIG_LSB = 16;
  localparam int RUN_BIT = 3;
  localparam int CLEAR_BIT = 2;
  localparam int SRC_MSB = 1;
  localparam int SRC_LSB = 0;
  localparam logic [1:0] SRC_RED = 2'h0;
  localparam logic [1:0] SRC_GREEN = 2'h1;

  // feedback taps of the signature register
  localparam logic [SIG_W-1:0] SIG_POLY = 16'h1021;

  // interrupt causes
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FRAME = 1;

  // ----------------------------------------
  // empty-entry levels by threshold code
  // ----------------------------------------
  localparam logic [COUNT_W-1:0] LEVEL_TABLE [8] = '{
    5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h0a, 5'h0c
  };

  function automatic logic [COUNT_W-1:0] fetchLevel(input logic [2:0] code);
    return LEVEL_TABLE[code];
  endfunction : fetchLevel

  typedef enum logic [1:0] {ANA_IDLE, ANA_ARMED, ANA_ACTIVE} vfs_ana_state_type;

endpackage : vfs_pkg

// File: verilog/vfs_signature.sv
// signature shift register folding one colour byte per pixel
`timescale 1ns/1ns
module vfs_signature (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic forceZero,
  input wire logic shiftEn,
  input wire logic [7:0] dataIn,
  // result
  output logic [vfs_pkg::SIG_W-1:0] signature
);
  import vfs_pkg::*;

  logic [SIG_W-1:0] sigReg;
  logic [SIG_W-1:0] sigNext;

  // ----------------------------------------
  // shift register
  // ----------------------------------------
  always_comb begin
    sigNext = {sigReg[SIG_W-2:0], 1'b0} ^ (sigReg[SIG_W-1] ? SIG_POLY : '0)
      ^ {8'h00, dataIn};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sigReg <= '0;
    end else if (forceZero) begin
      sigReg <= '0;
    end else if (shiftEn) begin
      sigReg <= sigNext;
    end
  end

  assign signature = sigReg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_clear_forces_zero: assert property (
    @(posedge clk) disable iff (!rst_n) forceZero |=> (sigReg == '0)
  ) else $error("signature not zero while clear flag held");

  a_hold_when_idle: assert property (
    @(posedge clk) disable iff (!rst_n) !forceZero && !shiftEn |=> $stable(sigReg)
  ) else $error("signature moved without a pixel");

endmodule : vfs_signature

// File: test/tb.sv
// testbench for the fetch level and signature register block
`timescale 1ns/1ns
module tb;
  import vfs_pkg::*;
  // ----------------------------------------
  // design ports
  // ----------------------------------------
  logic clk = 1'b0, rst_n = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  vfs_addr_type paddr = '0;
  vfs_data_type pwdata = '0, prdata;
  logic pready, pslverr, irq, graphicsReq, windowOneReq, windowTwoReq;
  logic vsyncPulse = 1'b0, pixelValid = 1'b0;
  vfs_pixel_type pixelIn = '0;
  logic [LINE_W-1:0] scanLine = '0;
  logic [COUNT_W-1:0] graphicsEmpty = '0, windowOneEmpty = '0, windowTwoEmpty = '0;
  // ----------------------------------------
  // bench state
  // ----------------------------------------
  typedef struct packed {vfs_data_type data; vfs_data_type mask; logic err;} vfs_exp_type;
  vfs_exp_type expQ[$];
  vfs_exp_type e;
  int miscompares = 0, checksDone = 0, cycles = 0;
  logic [4:0] lvl [8] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h0a, 5'h0c};
  vfs_regs i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vsyncPulse(vsyncPulse), .pixelValid(pixelValid), .pixelIn(pixelIn), .scanLine(scanLine),
    .graphicsEmpty(graphicsEmpty), .windowOneEmpty(windowOneEmpty),
    .windowTwoEmpty(windowTwoEmpty), .graphicsReq(graphicsReq), .windowOneReq(windowOneReq),
    .windowTwoReq(windowTwoReq), .irq(irq));
  initial begin
    forever #25 clk = ~clk;
  end
  // ----------------------------------------
  // compare tasks and report
  // ----------------------------------------
  task automatic summarize;
    if (expQ.size() != 0) miscompares++;
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic checkRead(input vfs_data_type got, input vfs_data_type exp, input logic gotErr,
                           input logic expErr);
    checksDone++;
    if (got !== exp || gotErr !== expErr) begin
      miscompares++;
      $display("[ERR] %0t read %h err %b, expected %h err %b", $time, got, gotErr, exp, expErr);
    end
  endtask : checkRead
  task automatic checkLevel(input logic got, input logic exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t level output %b, expected %b", $time, got, exp);
    end
  endtask : checkLevel
  // answers are taken only at the edge where pready is seen with the request
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (expQ.size() == 0) checkRead(prdata, 'x, pslverr, 1'bx);
      else begin
        e = expQ.pop_front();
        checkRead(prdata & e.mask, e.data & e.mask, pslverr, e.err);
      end
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic apb(input logic wr, input vfs_addr_type a, input vfs_data_type wd,
                     input vfs_data_type ed, input vfs_data_type m, input logic er);
    expQ.push_back('{ed, m, er});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input vfs_addr_type a, input vfs_data_type d);
    apb(1'b1, a, d, '0, '0, 1'b0);
  endtask : wr
  task automatic rd(input vfs_addr_type a, input vfs_data_type d, input vfs_data_type m);
    apb(1'b0, a, '0, d, m, 1'b0);
  endtask : rd
  task automatic vsync;
    @(posedge clk);
    vsyncPulse <= 1'b1;
    @(posedge clk);
    vsyncPulse <= 1'b0;
  endtask : vsync
  task automatic setEmpty(input logic [4:0] g, input logic [4:0] a, input logic [4:0] b);
    @(posedge clk);
    graphicsEmpty <= g;
    windowOneEmpty <= a;
    windowTwoEmpty <= b;
    repeat (3) @(posedge clk);
  endtask : setEmpty
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    vfs_data_type w;
    logic [8:0] code;
    logic [4:0] cnt [3];
    logic [15:0] sig;
    logic [7:0] px;
    void'($urandom(32'he6bb7e8f));
    // a real falling edge at time zero, so the reset branch runs before the first clock
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFF_FETCH_THRESHOLD, 32'h00000444, '1);
    rd(OFF_COLOUR_CONSTANTS, 32'h00ededed, '1);
    setEmpty(5'h06, 5'h05, 5'h06);
    checkLevel(graphicsReq, 1'b1);
    checkLevel(windowOneReq, 1'b0);
    for (int c = 0; c < 8; c++) begin
      code = {3'(c), 3'(c + 3), 3'(c + 5)};
      w = $urandom;
      w[10:8] = code[8:6];
      w[6:4] = code[5:3];
      w[2:0] = code[2:0];
      wr(OFF_FETCH_THRESHOLD, w);
      rd(OFF_FETCH_THRESHOLD, w & 32'h00000777, '1);
      for (int k = 0; k < 3; k++) begin
        for (int b = 0; b < 3; b++) cnt[b] = k == 2 ? 5'($urandom) : lvl[code[3*b+:3]] - 5'(k);
        setEmpty(cnt[0], cnt[1], cnt[2]);
        checkLevel(graphicsReq, cnt[0] >= lvl[code[2:0]]);
        checkLevel(windowOneReq, cnt[1] >= lvl[code[5:3]]);
        checkLevel(windowTwoReq, cnt[2] >= lvl[code[8:6]]);
      end
    end
    w = $urandom;
    wr(OFF_COLOUR_CONSTANTS, w);
    rd(OFF_COLOUR_CONSTANTS, w & 32'h00ffffff, '1);
    @(posedge clk);
    scanLine <= LINE_W'($urandom);
    w = $urandom;
    wr(OFF_LINE_POSITION, w);
    rd(OFF_LINE_POSITION, {21'h0, scanLine}, '1);
    apb(1'b1, 12'h068, w, '0, '0, 1'b1);
    apb(1'b0, 12'h068, '0, '0, '1, 1'b1);
    wr(OFF_IRQ_ENABLE, 32'h00000001);
    // source 2 and 3 both pick blue, so all four codes run
    for (int s = 0; s < 4; s++) begin
      w = $urandom;
      w[3:0] = {2'b11, 2'(s)};
      wr(OFF_SIGNATURE_CTRL, w);
      rd(OFF_SIGNATURE_CTRL, 32'h0000000c | s, '1);
      vsync();
      rd(OFF_SIGNATURE_CTRL, 32'h00000008 | s, 32'h0000ffff);
      sig = '0;
      for (int p = 0; p < 6; p++) begin
        @(posedge clk);
        pixelValid <= 1'b1;
        pixelIn <= 24'($urandom);
        #1 px = s == 0 ? pixelIn.red : s == 1 ? pixelIn.green : pixelIn.blue;
        sig = (sig << 1) ^ (sig[15] ? 16'h1021 : 16'h0000) ^ {8'h00, px};
      end
      @(posedge clk);
      pixelValid <= 1'b0;
      repeat (4) @(posedge clk);
      vsync();
      repeat (2) @(posedge clk);
      rd(OFF_SIGNATURE_CTRL, {sig, 14'h0, 2'(s)}, '1);
    end
    checkLevel(irq, 1'b1);
    rd(OFF_IRQ_STATUS, 32'h00000003, '1);
    wr(OFF_IRQ_ENABLE, 32'h00000000);
    repeat (2) @(posedge clk);
    checkLevel(irq, 1'b0);
    wr(OFF_IRQ_ENABLE, 32'h00000001);
    wr(OFF_IRQ_CLEAR, 32'h00000003);
    repeat (2) @(posedge clk);
    checkLevel(irq, 1'b0);
    rd(OFF_IRQ_STATUS, 32'h00000000, '1);
    // a run armed and then withdrawn by software reads back stopped
    wr(OFF_SIGNATURE_CTRL, 32'h00000008);
    rd(OFF_SIGNATURE_CTRL, 32'h00000008, 32'h0000ffff);
    wr(OFF_SIGNATURE_CTRL, 32'h00000000);
    rd(OFF_SIGNATURE_CTRL, 32'h00000000, 32'h0000ffff);
    repeat (2) @(posedge clk);
    summarize();
  end
endmodule : tb
